/* rhd_pkg.sv */
// ==========================================================================
// root hub descriptor register bank constants
package rhd_pkg;

  // command codes on the processor port
  localparam logic [7:0] RHD_CMD_DESC_A_RD  = 8'h12;
  localparam logic [7:0] RHD_CMD_DESC_A_WR  = 8'h92;
  localparam logic [7:0] RHD_CMD_DESC_B_RD  = 8'h13;
  localparam logic [7:0] RHD_CMD_DESC_B_WR  = 8'h93;
  localparam logic [7:0] RHD_CMD_GSTAT_RD   = 8'h14;
  localparam logic [7:0] RHD_CMD_GSTAT_WR   = 8'h94;
  localparam logic [7:0] RHD_CMD_PORT1_RD   = 8'h15;
  localparam logic [7:0] RHD_CMD_PORT1_WR   = 8'h95;
  localparam logic [7:0] RHD_CMD_PORT2_RD   = 8'h16;
  localparam logic [7:0] RHD_CMD_PORT2_WR   = 8'h96;

  // descriptor A field positions
  localparam int RHD_PGOOD_WAIT_LSB   = 24;
  localparam int RHD_NO_OC_PROT_BIT   = 12;
  localparam int RHD_OC_MODE_BIT      = 11;
  localparam int RHD_COMPOUND_BIT     = 10;
  localparam int RHD_ALWAYS_PWR_BIT   = 9;
  localparam int RHD_SWITCH_STYLE_BIT = 8;

  // descriptor A writable mask: bits 31:24, 12, 11, 9, 8
  localparam logic [31:0] RHD_DESC_A_WMASK = 32'hff00_1b00;
  // descriptor B writable mask: bits 18:16, 2:0
  localparam logic [31:0] RHD_DESC_B_WMASK = 32'h0007_0007;

  // reset values
  localparam logic [7:0]  RHD_PGOOD_WAIT_RST   = 8'h01;
  localparam logic        RHD_NO_OC_PROT_RST   = 1'b0;
  localparam logic        RHD_ALWAYS_PWR_RST   = 1'b0;
  localparam logic        RHD_SWITCH_STYLE_RST = 1'b1;
  localparam logic [31:0] RHD_DESC_B_RST = 32'h0000_0000;
  localparam logic [31:0] RHD_GSTAT_RST  = 32'h0000_0000;
  localparam logic [31:0] RHD_PORT_RST   = 32'h0000_0000;

  // power-good delay unit in ms
  localparam int RHD_PGOOD_WAIT_UNIT_MS = 2;

endpackage

/* rhd_regs.sv */
// Contract
// - registers accessed only as full 32-bit words
// - two descriptors, global status, per-port status
// - descriptor writes accepted in every state
// - status writes accepted only when operational
// - descriptor A read 12h, write 92h
// - bits 31:24 power-good delay, 2 ms units
// - bit 12 set disables overcurrent reporting
// - bit 11 picks collective or per-port reporting
// - reset loads bit 11 from bit 8
// - bit 10 reads zero, ignores writes
// - descriptor length, type, current not stored
// - bit 9 set keeps ports always powered
// - bit 8 picks ganged or per-port switching
// - bits 1:0 read-only port count, max 2
`timescale 1ns/1ps

module rhd_regs #(
  parameter int PORT_COUNT = 2
) (
  input  wire logic        sys_clk_i,              // controller clock, 25 MHz
  input  wire logic        srst_i,                 // synchronous reset, active high
  input  wire logic        cmd_valid_i,            // command strobe, one cycle
  input  wire logic [7:0]  cmd_code_i,             // command code, bit 7 set = write
  input  wire logic [31:0] wr_data_i,              // full word write data
  input  wire logic        operational_bus_state_i, // controller in operational state
  output logic [31:0]      rd_data_o,              // read data, registered
  output logic             rd_valid_o,             // read data valid pulse
  output logic             wr_refused_o,           // status write refused pulse
  output logic [7:0]       power_good_wait_count_o, // power-good delay count
  output logic             no_overcurrent_protect_o, // overcurrent reporting off
  output logic             overcurrent_report_mode_o, // per-port overcurrent
  output logic             ports_always_powered_o, // no power switching
  output logic             power_switch_style_o    // per-port switching
);

  // ==========================================================================
  // elaboration checks
  if (PORT_COUNT < 1 || PORT_COUNT > 2) begin : g_bad_port_count
    $error("port count must be 1 or 2");
  end

  // ==========================================================================
  // state
  logic [7:0]  pgood_wait_reg;
  logic [7:0]  pgood_wait_next;
  logic        no_oc_prot_reg;
  logic        no_oc_prot_next;
  logic        oc_mode_reg;
  logic        oc_mode_next;
  logic        always_pwr_reg;
  logic        always_pwr_next;
  logic        switch_style_reg;
  logic        switch_style_next;
  logic [31:0] desc_b_reg;
  logic [31:0] desc_b_next;
  logic [31:0] gstat_reg;
  logic [31:0] gstat_next;
  logic [31:0] port_reg [2];
  logic [31:0] port_next [2];
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;
  logic        rd_valid_reg;
  logic        rd_valid_next;
  logic        refused_reg;
  logic        refused_next;

  localparam logic [1:0] PORT_CNT_VAL  = 2'(PORT_COUNT);
  localparam logic       PORT2_PRESENT = (PORT_COUNT > 1);

  // ==========================================================================
  // helpers
  // descriptor A as software sees it; emulated hub fields are not stored
  function automatic logic [31:0] desc_a_word(input logic [7:0] pg,
                                              input logic       nc,
                                              input logic       om,
                                              input logic       np,
                                              input logic       ps);
    logic [31:0] w;
    w                                   = 32'h0000_0000;
    w[rhd_pkg::RHD_PGOOD_WAIT_LSB +: 8] = pg;
    w[rhd_pkg::RHD_NO_OC_PROT_BIT]      = nc;
    w[rhd_pkg::RHD_OC_MODE_BIT]         = om;
    w[rhd_pkg::RHD_COMPOUND_BIT]        = 1'b0;
    w[rhd_pkg::RHD_ALWAYS_PWR_BIT]      = np;
    w[rhd_pkg::RHD_SWITCH_STYLE_BIT]    = ps;
    w[1:0]                              = PORT_CNT_VAL;
    return w;
  endfunction

  // status and port words only change while operational
  function automatic logic status_write_ok(input logic operational, input logic present);
    return operational && present;
  endfunction

  // ==========================================================================
  // next-state logic
  always_comb begin
    logic [31:0] wd;
    wd                = wr_data_i;
    pgood_wait_next   = pgood_wait_reg;
    no_oc_prot_next   = no_oc_prot_reg;
    oc_mode_next      = oc_mode_reg;
    always_pwr_next   = always_pwr_reg;
    switch_style_next = switch_style_reg;
    desc_b_next       = desc_b_reg;
    gstat_next        = gstat_reg;
    port_next[0]      = port_reg[0];
    port_next[1]      = port_reg[1];
    rd_data_next      = 32'h0000_0000;
    rd_valid_next     = 1'b0;
    refused_next      = 1'b0;
    if (cmd_valid_i) begin
      case (cmd_code_i)
        rhd_pkg::RHD_CMD_DESC_A_RD: begin
          rd_data_next  = desc_a_word(pgood_wait_reg, no_oc_prot_reg, oc_mode_reg,
                                      always_pwr_reg, switch_style_reg);
          rd_valid_next = 1'b1;
        end
        rhd_pkg::RHD_CMD_DESC_A_WR: begin
          pgood_wait_next   = wd[rhd_pkg::RHD_PGOOD_WAIT_LSB +: 8];
          no_oc_prot_next   = wd[rhd_pkg::RHD_NO_OC_PROT_BIT];
          oc_mode_next      = wd[rhd_pkg::RHD_OC_MODE_BIT];
          always_pwr_next   = wd[rhd_pkg::RHD_ALWAYS_PWR_BIT];
          switch_style_next = wd[rhd_pkg::RHD_SWITCH_STYLE_BIT];
        end
        rhd_pkg::RHD_CMD_DESC_B_RD: begin
          rd_data_next  = desc_b_reg;
          rd_valid_next = 1'b1;
        end
        rhd_pkg::RHD_CMD_DESC_B_WR: begin
          desc_b_next = wd & rhd_pkg::RHD_DESC_B_WMASK;
        end
        rhd_pkg::RHD_CMD_GSTAT_RD: begin
          rd_data_next  = gstat_reg;
          rd_valid_next = 1'b1;
        end
        rhd_pkg::RHD_CMD_GSTAT_WR: begin
          if (status_write_ok(operational_bus_state_i, 1'b1)) begin
            gstat_next = wd;
          end else begin
            refused_next = 1'b1;
          end
        end
        rhd_pkg::RHD_CMD_PORT1_RD: begin
          rd_data_next  = port_reg[0];
          rd_valid_next = 1'b1;
        end
        rhd_pkg::RHD_CMD_PORT1_WR: begin
          if (status_write_ok(operational_bus_state_i, 1'b1)) begin
            port_next[0] = wd;
          end else begin
            refused_next = 1'b1;
          end
        end
        rhd_pkg::RHD_CMD_PORT2_RD: begin
          rd_data_next  = PORT2_PRESENT ? port_reg[1] : 32'h0000_0000;
          rd_valid_next = 1'b1;
        end
        rhd_pkg::RHD_CMD_PORT2_WR: begin
          if (status_write_ok(operational_bus_state_i, PORT2_PRESENT)) begin
            port_next[1] = wd;
          end else begin
            refused_next = 1'b1;
          end
        end
        default: begin
          rd_data_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pgood_wait_reg   <= rhd_pkg::RHD_PGOOD_WAIT_RST;
      no_oc_prot_reg   <= rhd_pkg::RHD_NO_OC_PROT_RST;
      // report mode starts equal to switch style
      oc_mode_reg      <= rhd_pkg::RHD_SWITCH_STYLE_RST;
      always_pwr_reg   <= rhd_pkg::RHD_ALWAYS_PWR_RST;
      switch_style_reg <= rhd_pkg::RHD_SWITCH_STYLE_RST;
      desc_b_reg       <= rhd_pkg::RHD_DESC_B_RST;
      gstat_reg        <= rhd_pkg::RHD_GSTAT_RST;
      port_reg[0]      <= rhd_pkg::RHD_PORT_RST;
      port_reg[1]      <= rhd_pkg::RHD_PORT_RST;
      rd_data_reg      <= 32'h0000_0000;
      rd_valid_reg     <= 1'b0;
      refused_reg      <= 1'b0;
    end else begin
      pgood_wait_reg   <= pgood_wait_next;
      no_oc_prot_reg   <= no_oc_prot_next;
      oc_mode_reg      <= oc_mode_next;
      always_pwr_reg   <= always_pwr_next;
      switch_style_reg <= switch_style_next;
      desc_b_reg       <= desc_b_next;
      gstat_reg        <= gstat_next;
      port_reg[0]      <= port_next[0];
      port_reg[1]      <= port_next[1];
      rd_data_reg      <= rd_data_next;
      rd_valid_reg     <= rd_valid_next;
      refused_reg      <= refused_next;
    end
  end

  // ==========================================================================
  // outputs
  assign rd_data_o                 = rd_data_reg;
  assign rd_valid_o                = rd_valid_reg;
  assign wr_refused_o              = refused_reg;
  assign power_good_wait_count_o   = pgood_wait_reg;
  assign no_overcurrent_protect_o  = no_oc_prot_reg;
  assign overcurrent_report_mode_o = oc_mode_reg;
  assign ports_always_powered_o    = always_pwr_reg;
  assign power_switch_style_o      = switch_style_reg;

endmodule

/* rhd_regs_monitor.sv */
`timescale 1ns/1ps
// ==========================================================================
// register bank checker
module rhd_regs_monitor #(parameter int PORT_COUNT = 2) (
  input logic        sys_clk_i,                 // controller clock
  input logic        srst_i,                    // synchronous reset
  input logic        cmd_valid_i,               // command strobe
  input logic [7:0]  cmd_code_i,                // command code
  input logic [31:0] wr_data_i,                 // write word
  input logic        operational_bus_state_i,   // operational state
  input logic [31:0] rd_data_o,                 // read word
  input logic        rd_valid_o,                // read word valid
  input logic        wr_refused_o,              // refusal pulse
  input logic [7:0]  power_good_wait_count_o,   // power-good delay
  input logic        no_overcurrent_protect_o,  // reporting off
  input logic        overcurrent_report_mode_o, // per-port reporting
  input logic        ports_always_powered_o,    // no switching
  input logic        power_switch_style_o       // per-port switching
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  logic [31:0] cfg;
  assign cfg = {power_good_wait_count_o, 11'h0, no_overcurrent_protect_o,
    overcurrent_report_mode_o, 1'b0, ports_always_powered_o, power_switch_style_o,
    6'h0, 2'(PORT_COUNT)};
  sequence s_wr_a; cmd_valid_i && cmd_code_i == 8'h92; endsequence
  sequence s_rd_a; cmd_valid_i && cmd_code_i == 8'h12; endsequence
  sequence s_st_wr; cmd_valid_i && cmd_code_i inside {8'h94, 8'h95}; endsequence
  a_read_desc_a:
    assert property (s_rd_a |=> rd_valid_o && rd_data_o == $past(cfg)) else $error("bad read");
  a_write_desc_a:
    assert property (s_wr_a |=> cfg == (($past(wr_data_i) & 32'hff00_1b00) | 32'(PORT_COUNT)))
      else $error("bad write");
  a_type_zero:
    assert property (s_rd_a |=> rd_valid_o && !rd_data_o[10]) else $error("type flag set");
  a_status_refused:
    assert property (s_st_wr ##0 !operational_bus_state_i |=> wr_refused_o)
      else $error("no refusal");
  a_status_taken:
    assert property (s_st_wr ##0 operational_bus_state_i |=> !wr_refused_o)
      else $error("wrong refusal");
  a_status_roundtrip:
    assert property (s_st_wr ##0 operational_bus_state_i ##1 !cmd_valid_i ##1
      cmd_valid_i && cmd_code_i == ($past(cmd_code_i, 2) ^ 8'h80)
      |=> rd_data_o == $past(wr_data_i, 3)) else $error("status lost");
  a_config_hold:
    assert property (!(cmd_valid_i && cmd_code_i == 8'h92) |=> $stable(cfg))
      else $error("config moved");
  a_reset_load:
    assert property (@(posedge sys_clk_i) disable iff (1'b0)
      srst_i |=> cfg == (32'h0100_0900 | 32'(PORT_COUNT))) else $error("bad reset");
endmodule

bind rhd_regs rhd_regs_monitor #(
  .PORT_COUNT(PORT_COUNT)
) u_mon (
  .sys_clk_i                (sys_clk_i),
  .srst_i                   (srst_i),
  .cmd_valid_i              (cmd_valid_i),
  .cmd_code_i               (cmd_code_i),
  .wr_data_i                (wr_data_i),
  .operational_bus_state_i  (operational_bus_state_i),
  .rd_data_o                (rd_data_o),
  .rd_valid_o               (rd_valid_o),
  .wr_refused_o             (wr_refused_o),
  .power_good_wait_count_o  (power_good_wait_count_o),
  .no_overcurrent_protect_o (no_overcurrent_protect_o),
  .overcurrent_report_mode_o(overcurrent_report_mode_o),
  .ports_always_powered_o   (ports_always_powered_o),
  .power_switch_style_o     (power_switch_style_o)
);

/* rhd_host.sv */
`timescale 1ns/1ps
// ==========================================================================
// host driver software model
module rhd_host (
  input  logic        sys_clk_i,    // controller clock
  input  logic [31:0] rd_data_i,    // read word
  input  logic        rd_valid_i,   // read word valid
  input  logic        wr_refused_i, // refusal pulse
  output logic        cmd_valid_o,  // command strobe
  output logic [7:0]  cmd_code_o,   // command code
  output logic [31:0] wr_data_o     // write word
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o  = 8'h00;
    wr_data_o   = 32'h0;
  end
  // one whole word per command; idle lines never keep the last value
  task automatic xfer(input logic [7:0] code, input logic [31:0] data,
                      output logic [31:0] rd, output logic v, output logic rf);
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o  = code;
    wr_data_o   = code[7] ? data : ~wr_data_o;
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b0;
    cmd_code_o  = ~code;
    wr_data_o   = ~wr_data_o;
    rd = rd_data_i;
    v  = rd_valid_i;
    rf = wr_refused_i;
  endtask
  // power-up: clear then set per-port overcurrent mode
  task automatic setup_oc_report(input logic [31:0] base);
    logic [31:0] rd;
    logic v, rf;
    xfer(8'h92, base & ~32'h800, rd, v, rf);
    xfer(8'h92, base | 32'h800, rd, v, rf);
  endtask
endmodule

/* rhd_regs_test.sv */
`timescale 1ns/1ps
module rhd_regs_test;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic op = 1'b0;
  logic cv, v, rf;
  logic [7:0] cc;
  logic [31:0] wd, rdo, rd;
  logic rvo, wro, noc, ocm, apw, sws;
  logic [7:0] pgw;
  int errors = 0;
  int num_checks = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  rhd_regs DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .cmd_valid_i(cv), .cmd_code_i(cc),
    .wr_data_i(wd), .operational_bus_state_i(op), .rd_data_o(rdo), .rd_valid_o(rvo),
    .wr_refused_o(wro), .power_good_wait_count_o(pgw), .no_overcurrent_protect_o(noc),
    .overcurrent_report_mode_o(ocm), .ports_always_powered_o(apw), .power_switch_style_o(sws));
  rhd_host host (.sys_clk_i(sys_clk_i), .rd_data_i(rdo), .rd_valid_i(rvo),
    .wr_refused_i(wro), .cmd_valid_o(cv), .cmd_code_o(cc), .wr_data_o(wd));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_reset;
    host.xfer(8'h12, 32'h0, rd, v, rf);
    check({31'h0, v}, 32'h1);
    check(rd, 32'h0100_0902);
    check({20'h0, pgw, noc, ocm, apw, sws}, 32'h0000_0015);
    host.xfer(8'h20, 32'h0, rd, v, rf);
    check({31'h0, v}, 32'h0);
    check({31'h0, rf}, 32'h0);
  endtask
  task automatic t_desc_a;
    host.xfer(8'h92, 32'hffff_ffff, rd, v, rf);
    check({31'h0, rf}, 32'h0);
    check({20'h0, pgw, noc, ocm, apw, sws}, 32'h0000_0fff);
    host.xfer(8'h12, 32'h0, rd, v, rf);
    check(rd, 32'hff00_1b02);
    host.setup_oc_report(32'h0000_0000);
    host.xfer(8'h12, 32'h0, rd, v, rf);
    check(rd, 32'h0000_0802);
    check({20'h0, pgw, noc, ocm, apw, sws}, 32'h0000_0004);
    op = 1'b1;
    host.xfer(8'h93, 32'hffff_ffff, rd, v, rf);
    host.xfer(8'h13, 32'h0, rd, v, rf);
    check(rd, 32'h0007_0007);
  endtask
  task automatic t_status;
    logic [7:0] c;
    for (int i = 0; i < 3; i++) begin
      c = 8'h94 + 8'(i);
      op = 1'b0;
      host.xfer(c, 32'h5a5a_0000 | i, rd, v, rf);
      check({31'h0, rf}, 32'h1);
      host.xfer(c ^ 8'h80, 32'h0, rd, v, rf);
      check(rd, 32'h0);
      op = 1'b1;
      host.xfer(c, 32'ha5a5_0000 | i, rd, v, rf);
      check({31'h0, rf}, 32'h0);
      host.xfer(c ^ 8'h80, 32'h0, rd, v, rf);
      check(rd, 32'ha5a5_0000 | i);
    end
  endtask
  initial begin
    repeat (4000) @(posedge sys_clk_i);
    errors++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    srst_i = 1'b0;
    t_reset;
    t_desc_a;
    t_status;
    print_verdict;
  end
endmodule
